/* File: design/acs_defs.svh */
/*
 Offsets, field positions, reset values and timing counts for the
 calibration sequencer. Assumes a 100 MHz master clock and byte
 addressing on the register bus.
*/
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define ACS_OFS_CTRL       8'h00
`define ACS_OFS_STATUS     8'h04
`define ACS_OFS_IRQ_STATUS 8'h08
`define ACS_OFS_IRQ_MASK   8'h0C
`define ACS_OFS_DATA       8'h10
`define ACS_OFS_ZERO       8'h14
`define ACS_OFS_SLOPE      8'h18

// ------------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------------
`define ACS_IRQ_DONE       0
`define ACS_IRQ_IGNORED    1
`define ACS_CTRL_RESET     1'h1
`define ACS_MASK_RESET     2'h0
`define ACS_UNI_SHIFT      20
`define ACS_BI_SHIFT       19

// ------------------------------------------------------------------
// Timing counts in master clock cycles
// ------------------------------------------------------------------
`define ACS_STROBE_MIN     3'h4
`define ACS_SELF_CYCLES    3145655
`define ACS_SYS_OFS_CYCLES 1052599
`define ACS_SYS_GAIN_CYCLES 1068813
`define ACS_ONE_OFS_CYCLES 2117389
`define ACS_SETTLE_CYCLES  1024

`endif

/* File: design/acs_pkg.sv */
/*
 Types shared by the calibration sequencer: sequencer states,
 calibration kinds and measurement sources. No assumptions.
*/
package acs_pkg;

    // --------------------------------------------------------------
    // Sequencer state, one-hot
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h1,
        ST_CAL    = 3'h2,
        ST_SETTLE = 3'h4
    } acs_state_type;

    // Calibration kind, coded as {cal_select_a, cal_select_b}
    typedef enum logic [1:0] {
        KIND_SELF     = 2'h0,
        KIND_SYS_GAIN = 2'h1,
        KIND_ONE_OFS  = 2'h2,
        KIND_SYS_OFS  = 2'h3
    } acs_kind_type;

    typedef enum logic [1:0] {
        SRC_INPUT  = 2'h0,
        SRC_GROUND = 2'h1,
        SRC_REF    = 2'h2
    } acs_src_type;

endpackage : acs_pkg

/* File: design/acs_adc_calibration_sequencer.sv */
/*
 Calibration sequencer of a sigma-delta converter with an Avalon-MM
 register slave. Assumes reading and conv_word come from the filter
 on clk; strobe, selects and polarity are asynchronous pins.
*/
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "acs_defs.svh"

module acs_adc_calibration_sequencer #(
    parameter int SELF_CYCLES     = `ACS_SELF_CYCLES,
    parameter int SYS_OFS_CYCLES  = `ACS_SYS_OFS_CYCLES,
    parameter int SYS_GAIN_CYCLES = `ACS_SYS_GAIN_CYCLES,
    parameter int ONE_OFS_CYCLES  = `ACS_ONE_OFS_CYCLES,
    parameter int SETTLE_CYCLES   = `ACS_SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Calibration pins
    input  wire logic        calibrate_strobe,
    input  wire logic        cal_select_a,
    input  wire logic        cal_select_b,
    input  wire logic        polarity_select,
    // Converter datapath
    input  wire logic [23:0] reading,
    input  wire logic [19:0] conv_word,
    output logic      [1:0]  meas_source,
    output logic             data_ready_n,
    output logic      [19:0] data_word,
    // Avalon-MM slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Interrupt
    output logic             irq
);

    // --------------------------------------------------------------
    // Functions
    // --------------------------------------------------------------
    function automatic logic [21:0] cal_len(input logic [1:0] kind);
        case (kind)
            acs_pkg::KIND_SELF:     cal_len = 22'(SELF_CYCLES - 1);
            acs_pkg::KIND_SYS_OFS:  cal_len = 22'(SYS_OFS_CYCLES - 1);
            acs_pkg::KIND_SYS_GAIN: cal_len = 22'(SYS_GAIN_CYCLES - 1);
            default:                cal_len = 22'(ONE_OFS_CYCLES - 1);
        endcase
    endfunction : cal_len

    function automatic logic [23:0] calc_slope(input logic [23:0] span,
                                               input logic        bip);
        calc_slope = bip ? (span >> `ACS_BI_SHIFT)
                         : (span >> `ACS_UNI_SHIFT);
    endfunction : calc_slope

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    logic                  strobe_s1;
    logic                  strobe_s2;
    logic                  strobe_s3;
    logic                  sel_a_s1;
    logic                  sel_a_s2;
    logic                  sel_b_s1;
    logic                  sel_b_s2;
    logic                  pol_s1;
    logic                  pol_s2;
    acs_pkg::acs_state_type state;
    acs_pkg::acs_state_type next_state;
    logic [1:0]            kind;
    logic [1:0]            next_kind;
    logic [1:0]            sel_cap;
    logic [1:0]            next_sel_cap;
    logic [2:0]            high_cnt;
    logic [2:0]            next_high_cnt;
    logic [21:0]           cnt;
    logic [21:0]           next_cnt;
    logic [23:0]           zero_pt;
    logic [23:0]           next_zero_pt;
    logic [23:0]           full_pt;
    logic [23:0]           next_full_pt;
    logic [23:0]           slope;
    logic [23:0]           next_slope;
    logic                  offset_done;
    logic                  next_offset_done;
    logic                  two_step_done;
    logic                  next_two_step_done;
    logic [1:0]            next_meas_source;
    logic                  next_data_ready_n;
    logic [19:0]           next_data_word;
    logic                  cal_enable;
    logic                  next_cal_enable;
    logic [1:0]            irq_status;
    logic [1:0]            next_irq_status;
    logic [1:0]            irq_mask;
    logic [1:0]            next_irq_mask;
    logic                  next_irq;
    logic [31:0]           next_readdata;
    logic                  next_waitrequest;

    logic                  strobe_rise;
    logic                  strobe_fall;
    logic                  strobe_ok;
    logic                  bus_wr;
    logic [1:0]            ev;
    logic [23:0]           span;

    assign strobe_rise = strobe_s2 & ~strobe_s3;
    assign strobe_fall = ~strobe_s2 & strobe_s3;
    assign strobe_ok   = (high_cnt >= `ACS_STROBE_MIN);
    assign bus_wr      = write & ~waitrequest;
    assign span        = full_pt - zero_pt;

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    always_comb
    begin
        next_state         = state;
        next_kind          = kind;
        next_sel_cap       = sel_cap;
        next_high_cnt      = high_cnt;
        next_cnt           = cnt;
        next_zero_pt       = zero_pt;
        next_full_pt       = full_pt;
        next_slope         = slope;
        next_offset_done   = offset_done;
        next_two_step_done = two_step_done;
        next_meas_source   = meas_source;
        next_data_ready_n  = data_ready_n;
        next_data_word     = data_word;
        ev                 = 2'h0;

        // Width of the high phase, saturating at the minimum
        if (strobe_rise)
        begin
            next_high_cnt = 3'h1;
            if (state == acs_pkg::ST_IDLE)
            begin
                next_sel_cap = {sel_a_s2, sel_b_s2};
            end
        end
        else if (strobe_s2 && !strobe_ok)
        begin
            next_high_cnt = high_cnt + 3'h1;
        end

        // A full strobe ignored while a step runs is flagged so software can see the misuse
        if (strobe_fall && strobe_ok && state != acs_pkg::ST_IDLE)
        begin
            ev[`ACS_IRQ_IGNORED] = 1'b1;
        end

        case (state)
            acs_pkg::ST_IDLE:
            begin
                if (strobe_fall && strobe_ok && cal_enable)
                begin
                    next_state        = acs_pkg::ST_CAL;
                    next_kind         = sel_cap;
                    next_cnt          = cal_len(sel_cap);
                    next_data_ready_n = 1'b1;
                    next_meas_source  = (sel_cap == acs_pkg::KIND_SELF)
                                      ? acs_pkg::SRC_GROUND
                                      : acs_pkg::SRC_INPUT;
                end
            end
            acs_pkg::ST_CAL:
            begin
                // Running step holds ready high; strobes only set the ignored flag
                next_cnt = cnt - 22'h1;
                if (cnt == (cal_len(kind) >> 1)
                    && (kind == acs_pkg::KIND_SELF
                        || (kind == acs_pkg::KIND_ONE_OFS
                            && !two_step_done)))
                begin
                    // Zero point taken at half time, then reference
                    next_zero_pt     = reading;
                    next_meas_source = acs_pkg::SRC_REF;
                end
                if (cnt == 22'h0)
                begin
                    ev[`ACS_IRQ_DONE] = 1'b1;
                    next_meas_source  = acs_pkg::SRC_INPUT;
                    case (kind)
                        acs_pkg::KIND_SELF:
                        begin
                            next_full_pt = reading;
                            next_slope   = calc_slope(reading - zero_pt,
                                                      pol_s2);
                            next_offset_done   = 1'b0;
                            next_two_step_done = 1'b0;
                            next_cnt   = 22'(SETTLE_CYCLES - 1);
                            next_state = acs_pkg::ST_SETTLE;
                        end
                        acs_pkg::KIND_SYS_OFS:
                        begin
                            next_zero_pt = reading;
                            if (two_step_done)
                            begin
                                // Gain kept: full point moves with zero
                                next_full_pt = reading + span;
                            end
                            next_offset_done  = 1'b1;
                            next_data_word    = 20'h00000;
                            next_data_ready_n = 1'b0;
                            next_state        = acs_pkg::ST_IDLE;
                        end
                        acs_pkg::KIND_SYS_GAIN:
                        begin
                            next_full_pt = reading;
                            next_slope   = calc_slope(reading - zero_pt,
                                                      pol_s2);
                            // Gain without a prior offset step is not a pair
                            next_two_step_done = offset_done;
                            next_data_word    = 20'hFFFFF;
                            next_data_ready_n = 1'b0;
                            next_state        = acs_pkg::ST_IDLE;
                        end
                        default:
                        begin
                            if (two_step_done)
                            begin
                                next_zero_pt = reading;
                                next_full_pt = reading + span;
                            end
                            else
                            begin
                                next_full_pt = reading;
                                next_slope   = calc_slope(
                                    reading - zero_pt, pol_s2);
                            end
                            next_data_word    = 20'h00000;
                            next_data_ready_n = 1'b0;
                            next_state        = acs_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            acs_pkg::ST_SETTLE:
            begin
                next_cnt = cnt - 22'h1;
                if (cnt == 22'h0)
                begin
                    next_data_word    = conv_word;
                    next_data_ready_n = 1'b0;
                    next_state        = acs_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state = acs_pkg::ST_IDLE;
            end
        endcase
    end

    // --------------------------------------------------------------
    // Register slave and interrupt
    // --------------------------------------------------------------
    always_comb
    begin
        next_cal_enable  = cal_enable;
        next_irq_mask    = irq_mask;
        next_readdata    = readdata;
        next_waitrequest = 1'b1;
        // Set wins over a write-one clear in the same cycle
        next_irq_status  = irq_status | ev;
        if (bus_wr)
        begin
            case (address)
                `ACS_OFS_CTRL:
                    next_cal_enable = writedata[0];
                `ACS_OFS_IRQ_STATUS:
                    next_irq_status = (irq_status & ~writedata[1:0]) | ev;
                `ACS_OFS_IRQ_MASK:
                    next_irq_mask = writedata[1:0];
                default:
                    next_cal_enable = cal_enable;
            endcase
        end
        // One wait cycle: data loaded on the edge that drops waitrequest
        if ((read || write) && waitrequest)
        begin
            next_waitrequest = 1'b0;
            case (address)
                `ACS_OFS_CTRL:
                    next_readdata = {31'h0, cal_enable};
                `ACS_OFS_STATUS:
                    next_readdata = {24'h0, pol_s2, two_step_done,
                                     offset_done, kind, state};
                `ACS_OFS_IRQ_STATUS:
                    next_readdata = {30'h0, irq_status};
                `ACS_OFS_IRQ_MASK:
                    next_readdata = {30'h0, irq_mask};
                `ACS_OFS_DATA:
                    next_readdata = {12'h0, data_word};
                `ACS_OFS_ZERO:
                    next_readdata = {8'h0, zero_pt};
                `ACS_OFS_SLOPE:
                    next_readdata = {8'h0, slope};
                default:
                    next_readdata = 32'h0;
            endcase
        end
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            strobe_s1     <= 1'b0;
            strobe_s2     <= 1'b0;
            strobe_s3     <= 1'b0;
            sel_a_s1      <= 1'b0;
            sel_a_s2      <= 1'b0;
            sel_b_s1      <= 1'b0;
            sel_b_s2      <= 1'b0;
            pol_s1        <= 1'b0;
            pol_s2        <= 1'b0;
            state         <= acs_pkg::ST_IDLE;
            kind          <= 2'h0;
            sel_cap       <= 2'h0;
            high_cnt      <= 3'h0;
            cnt           <= 22'h0;
            zero_pt       <= 24'h0;
            full_pt       <= 24'h0;
            slope         <= 24'h0;
            offset_done   <= 1'b0;
            two_step_done <= 1'b0;
            meas_source   <= 2'h0;
            data_ready_n  <= 1'b1;
            data_word     <= 20'h0;
            cal_enable    <= `ACS_CTRL_RESET;
            irq_status    <= 2'h0;
            irq_mask      <= `ACS_MASK_RESET;
            irq           <= 1'b0;
            readdata      <= 32'h0;
            waitrequest   <= 1'b1;
        end
        else
        begin
            strobe_s1     <= calibrate_strobe;
            strobe_s2     <= strobe_s1;
            strobe_s3     <= strobe_s2;
            sel_a_s1      <= cal_select_a;
            sel_a_s2      <= sel_a_s1;
            sel_b_s1      <= cal_select_b;
            sel_b_s2      <= sel_b_s1;
            // Live level, never latched
            pol_s1        <= polarity_select;
            pol_s2        <= pol_s1;
            state         <= next_state;
            kind          <= next_kind;
            sel_cap       <= next_sel_cap;
            high_cnt      <= next_high_cnt;
            cnt           <= next_cnt;
            zero_pt       <= next_zero_pt;
            full_pt       <= next_full_pt;
            slope         <= next_slope;
            offset_done   <= next_offset_done;
            two_step_done <= next_two_step_done;
            meas_source   <= next_meas_source;
            data_ready_n  <= next_data_ready_n;
            data_word     <= next_data_word;
            cal_enable    <= next_cal_enable;
            irq_status    <= next_irq_status;
            irq_mask      <= next_irq_mask;
            irq           <= next_irq;
            readdata      <= next_readdata;
            waitrequest   <= next_waitrequest;
        end
    end

endmodule : acs_adc_calibration_sequencer

/* File: verif/acs_cal_asserts.sv */
/*
 Port checker for the calibration sequencer.
 Assumes one clock with reset high; bound below.
*/
`timescale 1ns/1ps
module acs_cal_asserts #(
    parameter int SELF = 40,
    parameter int OFS  = 20,
    parameter int GAIN = 24,
    parameter int ONE  = 30,
    parameter int SETL = 8
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Pins and outputs
    input wire logic        calibrate_strobe,
    input wire logic        cal_select_a,
    input wire logic        cal_select_b,
    input wire logic [19:0] conv_word,
    input wire logic        data_ready_n,
    input wire logic [19:0] data_word,
    // Register bus
    input wire logic        read,
    input wire logic        write,
    input wire logic        waitrequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic       strobe_q;
    logic       armed;
    logic [1:0] sel_q;
    logic [3:0] fall_cnt;
    int         hi_len;
    int         exp_len;
    always_comb
    begin
        case (sel_q)
            2'h0:    exp_len = SELF + SETL;
            2'h1:    exp_len = GAIN;
            2'h2:    exp_len = ONE;
            default: exp_len = OFS;
        endcase
    end
    // No rise before the first step, so its length is not checked
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            strobe_q <= 1'b0;
            armed    <= 1'b0;
            sel_q    <= 2'h0;
            fall_cnt <= 4'hF;
            hi_len   <= 0;
        end
        else
        begin
            strobe_q <= calibrate_strobe;
            hi_len   <= data_ready_n ? hi_len + 1 : 0;
            if ($rose(data_ready_n))
                armed <= 1'b1;
            if (strobe_q && !calibrate_strobe)
                fall_cnt <= 4'h0;
            else if (fall_cnt != 4'hF)
                fall_cnt <= fall_cnt + 4'h1;
            if (!strobe_q && calibrate_strobe && (!data_ready_n || !armed))
                sel_q <= {cal_select_a, cal_select_b};
        end
    end
    property p_ready_start;
        $rose(data_ready_n) |-> fall_cnt inside {[4'h1:4'h6]};
    endproperty
    a_ready_start: assert property (p_ready_start)
        else $error("no strobe fall");
    property p_ready_hold;
        $rose(data_ready_n) |-> data_ready_n [*8];
    endproperty
    a_ready_hold: assert property (p_ready_hold)
        else $error("ready short");
    property p_len;
        $fell(data_ready_n) && armed
            |-> hi_len >= exp_len - 2 && hi_len <= exp_len + 2;
    endproperty
    a_len: assert property (p_len)
        else $error("bad length");
    property p_zero_word;
        $fell(data_ready_n) && sel_q == 2'h3 |-> ##[0:1] data_word == 20'h0;
    endproperty
    a_zero_word: assert property (p_zero_word)
        else $error("zero word");
    property p_full_word;
        $fell(data_ready_n) && sel_q == 2'h1
            |-> ##[0:1] data_word == 20'hFFFFF;
    endproperty
    a_full_word: assert property (p_full_word)
        else $error("full word");
    property p_self_word;
        $fell(data_ready_n) && sel_q == 2'h0
            |-> ##[0:1] data_word == conv_word;
    endproperty
    a_self_word: assert property (p_self_word)
        else $error("self word");
    property p_wait_pulse;
        $fell(waitrequest) |=> waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse)
        else $error("wait too long");
    property p_wait_answer;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_wait_answer: assert property (p_wait_answer)
        else $error("no answer");
    c_self: cover property ($fell(data_ready_n) && sel_q == 2'h0);
    c_gain: cover property ($fell(data_ready_n) && sel_q == 2'h1);
    c_read: cover property (read && !waitrequest);
endmodule : acs_cal_asserts

bind acs_adc_calibration_sequencer acs_cal_asserts #(
    .SELF(SELF_CYCLES), .OFS(SYS_OFS_CYCLES), .GAIN(SYS_GAIN_CYCLES),
    .ONE(ONE_OFS_CYCLES), .SETL(SETTLE_CYCLES)
) u_chk (.clk, .rst, .calibrate_strobe, .cal_select_a, .cal_select_b,
    .conv_word, .data_ready_n, .data_word, .read, .write, .waitrequest);

/* File: verif/acs_host_model.sv */
/*
 Host that pulses the calibration strobe with chosen selects.
 Assumes the bench pulses go for one clock while busy is low.
*/
`timescale 1ns/1ps
module acs_host_model (
    // Clock
    input  wire logic       clk,
    // Bench commands
    input  wire logic       go,
    input  wire logic [1:0] sel,
    input  wire logic [3:0] hold,
    // Calibration pins
    output logic            calibrate_strobe,
    output logic            cal_select_a,
    output logic            cal_select_b,
    output logic            busy
);
    logic [3:0] cnt;
    initial
    begin
        {calibrate_strobe, cal_select_a, cal_select_b, busy, cnt} = 8'h0;
    end
    // Selects flip one clock after the strobe rises, so a device that samples them later than the rise is caught
    always @(posedge clk)
    begin
        if (go && !busy)
        begin
            {cal_select_a, cal_select_b} <= sel;
            busy <= 1'b1;
            cnt  <= 4'h0;
        end
        else if (busy)
        begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h0) calibrate_strobe <= 1'b1;
            if (cnt == 4'h1) {cal_select_a, cal_select_b} <= ~sel;
            if (cnt == hold)
            begin
                calibrate_strobe <= 1'b0;
                busy <= 1'b0;
            end
        end
    end
endmodule : acs_host_model

/* File: verif/acs_adc_calibration_sequencer_test.sv */
/*
 Self-checking bench for the calibration sequencer.
 Assumes the host model drives the calibration pins.
*/
`timescale 1ns/1ps
`include "acs_defs.svh"
module acs_adc_calibration_sequencer_test;
    localparam int SELF = 40;
    localparam int OFS  = 20;
    localparam int GAIN = 24;
    localparam int ONE  = 30;
    localparam int SETL = 8;
    logic clk, rst, calibrate_strobe, cal_select_a, cal_select_b;
    logic polarity_select, data_ready_n, read, write, waitrequest, irq;
    logic go, busy;
    logic [23:0] reading;
    logic [19:0] conv_word, data_word;
    logic [7:0]  address;
    logic [31:0] writedata, readdata, q;
    logic [1:0]  sel;
    logic [3:0]  hold;
    int          n_mismatch, checked;
    acs_adc_calibration_sequencer #(.SELF_CYCLES(SELF),
        .SYS_OFS_CYCLES(OFS), .SYS_GAIN_CYCLES(GAIN),
        .ONE_OFS_CYCLES(ONE), .SETTLE_CYCLES(SETL)) dut (.clk, .rst,
        .calibrate_strobe, .cal_select_a, .cal_select_b, .polarity_select,
        .reading, .conv_word, .meas_source(), .data_ready_n, .data_word,
        .address, .read, .write, .writedata, .readdata, .waitrequest, .irq);
    acs_host_model u_host (.clk, .go, .sel, .hold, .calibrate_strobe,
        .cal_select_a, .cal_select_b, .busy);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task chk_flag(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask : chk_flag
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask : bus
    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk_val(q, e);
    endtask : rdc
    task cal(input logic [1:0] s, input logic [3:0] h);
        @(posedge clk);
        sel  <= s;
        hold <= h;
        go   <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask : cal
    // Intr strobes again mid-step
    task step(input logic [1:0] s, input int len, input logic chk,
              input logic [19:0] w, input logic intr);
        int   n;
        logic seen;
        cal(s, 4'h5);
        do @(posedge clk); while (busy);
        n = 0;
        seen = 1'b0;
        do
        begin
            @(posedge clk);
            n++;
            seen = seen | (data_ready_n === 1'b1);
            go <= intr && (n == 6);
        end
        while (!(seen && data_ready_n === 1'b0) && n < 5000);
        chk_flag(n >= len && n <= len + 6, 1'b1);
        if (chk) chk_val({12'h0, data_word}, {12'h0, w});
        bus(1'b0, `ACS_OFS_IRQ_STATUS, 32'h0);
        chk_flag(q[0], 1'b1);
        bus(1'b1, `ACS_OFS_IRQ_STATUS, 32'h1);
    endtask : step
    task t_regs;
        rdc(`ACS_OFS_CTRL, 32'h1);
        rdc(`ACS_OFS_IRQ_MASK, 32'h0);
        bus(1'b1, `ACS_OFS_DATA, 32'hFFFFF);
        rdc(`ACS_OFS_DATA, 32'h0);
        rdc(8'h1C, 32'h0);
        chk_flag(data_ready_n, 1'b1);
        $display("t_regs done");
    endtask : t_regs
    task t_two(input logic pol, input logic [31:0] slope);
        polarity_select <= pol;
        reading <= 24'h000100;
        step(2'h3, OFS, 1'b1, 20'h00000, 1'b0);
        reading <= 24'h100100;
        step(2'h1, GAIN, 1'b1, 20'hFFFFF, 1'b0);
        rdc(`ACS_OFS_SLOPE, slope);
        bus(1'b0, `ACS_OFS_STATUS, 32'h0);
        chk_flag(q[6], 1'b1);
        reading <= 24'h000200;
        step(2'h3, OFS, 1'b1, 20'h00000, 1'b0);
        rdc(`ACS_OFS_SLOPE, slope);
        $display("t_two done");
    endtask : t_two
    task t_busy;
        step(2'h3, OFS, 1'b1, 20'h00000, 1'b1);
        bus(1'b0, `ACS_OFS_IRQ_STATUS, 32'h0);
        chk_val(q & 32'h2, 32'h2);
        chk_flag(irq, 1'b0);
        bus(1'b1, `ACS_OFS_IRQ_MASK, 32'h2);
        repeat (2) @(posedge clk);
        chk_flag(irq, 1'b1);
        bus(1'b1, `ACS_OFS_IRQ_STATUS, 32'h2);
        repeat (2) @(posedge clk);
        chk_flag(irq, 1'b0);
        $display("t_busy done");
    endtask : t_busy
    task t_refuse;
        int i, hi;
        for (i = 0; i < 2; i++)
        begin
            if (i == 1) bus(1'b1, `ACS_OFS_CTRL, 32'h0);
            cal(2'h0, (i == 0) ? 4'h2 : 4'h5);
            hi = 0;
            repeat (30)
            begin
                @(posedge clk);
                if (data_ready_n !== 1'b0) hi++;
            end
            chk_val(hi, 32'h0);
            rdc(`ACS_OFS_IRQ_STATUS, 32'h0);
        end
        bus(1'b1, `ACS_OFS_CTRL, 32'h1);
        $display("t_refuse done");
    endtask : t_refuse
    task close_out;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    initial
    begin
        {rst, polarity_select, read, write, go} = 5'h10;
        {address, writedata, reading, sel} = 66'h0;
        conv_word = 20'h5A5A5;
        hold = 4'h5;
        n_mismatch = 0;
        checked = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        step(2'h0, SELF + SETL, 1'b1, 20'h5A5A5, 1'b0);
        t_two(1'b0, 32'h1);
        t_two(1'b1, 32'h2);
        reading <= 24'h000100;
        step(2'h2, ONE, 1'b1, 20'h0, 1'b0);
        t_busy;
        t_refuse;
        close_out;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out;
    end
endmodule : acs_adc_calibration_sequencer_test
